// *** pkg/gpm_cfg.svh ***
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define GPM_OFS_MODE_LO 8'h00
`define GPM_OFS_MODE_HI 8'h04
`define GPM_OFS_INPUT 8'h08
`define GPM_OFS_LATCH 8'h0C
`define GPM_OFS_SET 8'h10
`define GPM_OFS_CLR 8'h14

// ----------------------------------------------------------------
// Field layout, mode codes and reset values
// ----------------------------------------------------------------
`define GPM_PINS 8
`define GPM_MODE_W 4
`define GPM_MODE_ANALOG 4'h0
`define GPM_MODE_IN_FLOAT 4'h4
`define GPM_MODE_IN_PULL 4'h8
`define GPM_MODE_OUT_PP 4'h1
`define GPM_MODE_OUT_OD 4'h5
`define GPM_MODE_ALT_PP 4'h9
`define GPM_MODE_ALT_OD 4'hD
`define GPM_MODE_RESET 16'h4444
`define GPM_LATCH_RESET 8'h00

`endif

// *** pkg/gpm_pkg.sv ***
package gpm_pkg;

  // Pad controls of one pin, as handed to the pad ring.
  typedef struct packed {
    logic analog;
    logic pull_up;
    logic pull_down;
    logic oe;
    logic out;
  } gpm_pad_t;

endpackage : gpm_pkg

// *** core/gpm_port.sv ***
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "gpm_cfg.svh"

// One eight-pin port: per-pin mode fields, an output latch with a
// bit-set and bit-clear path, and a synchronised input level register.
//
// Software sees six word registers on the register port. The two mode
// words hold four bits a pin, pins three to zero in the low word and
// pins seven to four in the high word, pin seven on top. The input level
// word is read only. The output latch reads and writes, and the set and
// clear words are write only and act on the latch bit by bit.
// Writes land at the edge that samples the strobe, reads answer in the
// next cycle, and pad controls follow one edge after what feeds them.
// Pins need three edges to reach the input level word, so a read issued
// straight after a pin change still shows the old level.
module gpm_port
  import gpm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] PIN_IN,
  input wire logic [7:0] ALT_OUT,
  output var gpm_pad_t [7:0] PAD
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------

  // Mode fields, pins three to zero in the low word.
  logic [15:0] mode_lo;
  // Mode fields, pins seven to four in the high word.
  logic [15:0] mode_hi;
  // Output latch; also picks the pull direction of pulled inputs.
  logic [7:0] pin_output_latch;
  // Level of each pin as software sees it.
  logic [7:0] pin_input_level;
  // First and second synchroniser stages.
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  // Both mode words side by side, indexed by pin.
  logic [31:0] mode_all;
  // Next pad controls, decoded from mode, latch and peripheral.
  gpm_pad_t [7:0] next_pad;
  // Next read data.
  logic [31:0] next_rdata;

  assign mode_all = {mode_hi, mode_lo};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Mode words. The high word holds pin seven in its top nibble.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_lo <= `GPM_MODE_RESET;
      mode_hi <= `GPM_MODE_RESET;
    end else if (WR) begin
      // A write to another offset leaves both words alone.
      if (ADDR == `GPM_OFS_MODE_LO) begin
        mode_lo <= WDATA[15:0];
      end
      if (ADDR == `GPM_OFS_MODE_HI) begin
        mode_hi <= WDATA[15:0];
      end
    end
  end

  // Output latch: direct write, bit-set and bit-clear.
  // The set path lets software touch one pin without a read-modify-write,
  // so an interrupt between read and write cannot undo another change.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_output_latch <= `GPM_LATCH_RESET;
    end else if (WR) begin
      case (ADDR)
        `GPM_OFS_LATCH: begin
          pin_output_latch <= WDATA[7:0];
        end
        `GPM_OFS_SET: begin
          // Ones set bits; zeros leave bits as they are.
          pin_output_latch <= pin_output_latch | WDATA[7:0];
        end
        `GPM_OFS_CLR: begin
          // Ones clear bits; zeros leave bits as they are.
          pin_output_latch <= pin_output_latch & ~WDATA[7:0];
        end
        default: begin
          // Other offsets do not touch the latch.
          pin_output_latch <= pin_output_latch;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------

  // Two-stage synchroniser; pins are asynchronous to CLK.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  // Input level register. Analog pins have no digital receiver, so they
  // read as one; other pins show the synchronised level. Pin seven is the
  // module type pin and is handled like any other.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_input_level <= 8'h00;
    end else begin
      for (int i = 0; i < `GPM_PINS; i++) begin
        if (mode_all[i*4 +: 4] == `GPM_MODE_ANALOG) begin
          pin_input_level[i] <= 1'b1;
        end else begin
          pin_input_level[i] <= sync_b[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad control decode
  // ----------------------------------------------------------------

  // Decode each pin's mode. Codes with no defined meaning fall back to a
  // floating input, so a bad write can never fight an outside driver.
  always_comb begin
    for (int i = 0; i < `GPM_PINS; i++) begin
      next_pad[i] = '0;
      case (mode_all[i*4 +: 4])
        `GPM_MODE_ANALOG: begin
          next_pad[i].analog = 1'b1;
        end
        `GPM_MODE_IN_FLOAT: begin
          // No pull and driver off: the defaults already say so.
          next_pad[i].oe = 1'b0;
        end
        `GPM_MODE_IN_PULL: begin
          // Latch one pulls up, latch zero pulls down.
          next_pad[i].pull_up = pin_output_latch[i];
          next_pad[i].pull_down = ~pin_output_latch[i];
        end
        `GPM_MODE_OUT_PP: begin
          next_pad[i].oe = 1'b1;
          next_pad[i].out = pin_output_latch[i];
        end
        `GPM_MODE_OUT_OD: begin
          // Drive only while the latch asks for low; high is external.
          next_pad[i].oe = ~pin_output_latch[i];
        end
        `GPM_MODE_ALT_PP: begin
          next_pad[i].oe = 1'b1;
          next_pad[i].out = ALT_OUT[i];
        end
        `GPM_MODE_ALT_OD: begin
          // Peripheral low pulls the pin down; no internal pull-up.
          next_pad[i].oe = ~ALT_OUT[i];
        end
        default: begin
          next_pad[i] = '0;
        end
      endcase
    end
  end

  // Pad controls leave from flip-flops, which costs one cycle of latency
  // but keeps decode glitches off the pins.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PAD <= '0;
    end else begin
      PAD <= next_pad;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read mux; unmapped offsets read zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (ADDR)
      `GPM_OFS_MODE_LO: begin
        next_rdata = {16'h0000, mode_lo};
      end
      `GPM_OFS_MODE_HI: begin
        next_rdata = {16'h0000, mode_hi};
      end
      `GPM_OFS_INPUT: begin
        next_rdata = {24'h000000, pin_input_level};
      end
      `GPM_OFS_LATCH: begin
        next_rdata = {24'h000000, pin_output_latch};
      end
      default: begin
        // Set and clear registers are write-only and read zero.
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // The checks below watch the registers and pad controls that this
  // block drives. All but the level and synchroniser checks look one edge
  // ahead, since every output here leaves a flip-flop, and they sleep while reset is high.
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  // Cycles since reset release, saturating, for checks looking back.
  logic [1:0] up_cnt;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      up_cnt <= 2'd0;
    end else if (up_cnt != 2'd3) begin
      up_cnt <= up_cnt + 2'd1;
    end
  end

  for (genvar g = 0; g < `GPM_PINS; g++) begin : g_chk
    AST_ANALOG_READS_ONE: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_ANALOG |=> pin_input_level[g] && PAD[g].analog)
      else $error("analog pin does not read one");
    AST_FLOAT_NO_DRIVE: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_IN_FLOAT
      |=> !PAD[g].oe && !PAD[g].pull_up && !PAD[g].pull_down)
      else $error("floating input drives or pulls");
    AST_PULL_ENABLED: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_IN_PULL
      |=> !PAD[g].oe && (PAD[g].pull_up != PAD[g].pull_down))
      else $error("pulled input has wrong pull or driver");
    AST_PULL_DIRECTION: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_IN_PULL
      |=> PAD[g].pull_up == $past(pin_output_latch[g]))
      else $error("pull direction does not follow latch");
    AST_PUSH_PULL: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_OUT_PP
      |=> PAD[g].oe && PAD[g].out == $past(pin_output_latch[g]))
      else $error("push-pull pin does not follow latch");
    AST_OPEN_DRAIN: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_OUT_OD
      |=> !PAD[g].out && !PAD[g].pull_up && PAD[g].oe == !$past(pin_output_latch[g]))
      else $error("open-drain pin misdriven");
    AST_ALT_PUSH_PULL: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_ALT_PP
      |=> PAD[g].oe && PAD[g].out == $past(ALT_OUT[g]))
      else $error("alternate push-pull not from peripheral");
    AST_ALT_OPEN_DRAIN: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_ALT_OD
      |=> !PAD[g].out && !PAD[g].pull_up && PAD[g].oe == !$past(ALT_OUT[g]))
      else $error("alternate open-drain misdriven");
    AST_LEVEL_SYNCED: assert property (
      up_cnt == 2'd3 && $past(mode_all[g*4 +: 4]) != `GPM_MODE_ANALOG
      |-> pin_input_level[g] == $past(PIN_IN[g], 3))
      else $error("input level not three cycles behind pin");
    // An analog pad must be left alone by the digital drivers and pulls.
    AST_ANALOG_NO_DRIVE: assert property (
      mode_all[g*4 +: 4] == `GPM_MODE_ANALOG
      |=> !PAD[g].oe && !PAD[g].pull_up && !PAD[g].pull_down)
      else $error("analog pin drives or pulls");
    // Undefined codes must look like a floating input at the pad.
    AST_UNDEFINED_FLOATS: assert property (
      !(mode_all[g*4 +: 4] inside {`GPM_MODE_ANALOG, `GPM_MODE_IN_FLOAT, `GPM_MODE_IN_PULL,
        `GPM_MODE_OUT_PP, `GPM_MODE_OUT_OD, `GPM_MODE_ALT_PP, `GPM_MODE_ALT_OD})
      |=> PAD[g] == '0)
      else $error("undefined mode does not float");
  end

  AST_PIN7_FIELD: assert property (
    WR && ADDR == `GPM_OFS_MODE_HI |=> mode_all[31:28] == $past(WDATA[15:12]))
    else $error("pin seven mode not in top of high word");
  AST_BIT_SET: assert property (
    WR && ADDR == `GPM_OFS_SET
    |=> pin_output_latch == ($past(pin_output_latch) | $past(WDATA[7:0])))
    else $error("bit-set write altered latch wrongly");
  AST_INPUT_READ: assert property (
    RD && ADDR == `GPM_OFS_INPUT |=> RDATA == {24'h000000, $past(pin_input_level)})
    else $error("input read does not show pin levels");

  // Word-level checks on the low mode word, the latch, the read port and the synchroniser.
  // A low word write must land there and leave the high word alone.
  AST_MODE_LO_WRITE: assert property (
    WR && ADDR == `GPM_OFS_MODE_LO
    |=> mode_lo == $past(WDATA[15:0]) && $stable(mode_hi))
    else $error("low mode write misplaced");
  // A direct latch write replaces all eight bits.
  AST_LATCH_WRITE: assert property (
    WR && ADDR == `GPM_OFS_LATCH |=> pin_output_latch == $past(WDATA[7:0]))
    else $error("latch write not taken");
  // A clear write drops the ones it names and keeps the rest.
  AST_BIT_CLEAR: assert property (
    WR && ADDR == `GPM_OFS_CLR
    |=> pin_output_latch == ($past(pin_output_latch) & ~$past(WDATA[7:0])))
    else $error("bit-clear write altered latch wrongly");
  // Writes elsewhere must not disturb the latch.
  AST_LATCH_HOLDS: assert property (
    !(WR && ADDR inside {`GPM_OFS_LATCH, `GPM_OFS_SET, `GPM_OFS_CLR})
    |=> $stable(pin_output_latch))
    else $error("latch changed without a latch write");
  // The set and clear words are write only and read back zero.
  AST_SET_CLR_READ: assert property (
    RD && ADDR inside {`GPM_OFS_SET, `GPM_OFS_CLR}
    |=> RDATA == 32'h0000_0000)
    else $error("write-only word reads nonzero");
  // Read data stand only in the cycle after a read strobe.
  AST_READ_IDLE_ZERO: assert property (
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data stands outside its cycle");
  // The second synchroniser stage takes only the first stage.
  AST_SYNC_CHAIN: assert property (
    sync_b == $past(sync_a))
    else $error("synchroniser stage skipped");

endmodule : gpm_port
`default_nettype wire

// *** test/gpm_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpm_cfg.svh"

// Compares one value, counts it and reports a mismatch at once.
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

// ----------------------------------------------------------------
// Self-checking bench for one eight-pin port
// ----------------------------------------------------------------
module testbench;
  import gpm_pkg::*;

  logic CLK; // Bench clock, 100 ns period.
  logic RESET; // Synchronous reset, active high.
  logic [7:0] ADDR; // Register byte address.
  logic [31:0] WDATA; // Write data.
  logic WR; // Write strobe.
  logic RD; // Read strobe.
  logic [31:0] RDATA; // Read data, one cycle after the strobe.
  logic [7:0] PIN_IN; // Levels seen on the pins.
  logic [7:0] ALT_OUT; // Peripheral outputs.
  gpm_pad_t [7:0] PAD; // Pad controls.
  int n_mismatch = 0; // Mismatches seen.
  int compares = 0; // Comparisons made.
  logic [31:0] rd_val; // Last word read.
  logic [3:0] codes [7] = '{`GPM_MODE_ANALOG, `GPM_MODE_IN_FLOAT, `GPM_MODE_IN_PULL,
    `GPM_MODE_OUT_PP, `GPM_MODE_OUT_OD, `GPM_MODE_ALT_PP, `GPM_MODE_ALT_OD};

  gpm_port uut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PIN_IN(PIN_IN), .ALT_OUT(ALT_OUT), .PAD(PAD));

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // One-cycle write; the strobe drops at the edge that took it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    rd_val = RDATA;
  endtask : rd

  // Expected {analog, pull_up, pull_down, oe, out}; out only counts while driven.
  function automatic logic [4:0] exp_pad(input logic [3:0] c, input logic l, input logic a);
    case (c)
      `GPM_MODE_ANALOG: return 5'h10;
      `GPM_MODE_IN_PULL: return {1'b0, l, ~l, 2'b00};
      `GPM_MODE_OUT_PP: return {4'h1, l};
      `GPM_MODE_OUT_OD: return {3'h0, ~l, 1'b0};
      `GPM_MODE_ALT_PP: return {4'h1, a};
      `GPM_MODE_ALT_OD: return {3'h0, ~a, 1'b0};
      default: return 5'h00;
    endcase
  endfunction : exp_pad

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset leaves every pin a floating input with the latch cleared.
  task automatic t_reset();
    rd(`GPM_OFS_MODE_HI);
    `CHK("mode_hi", 32'h0000_4444, rd_val)
    rd(`GPM_OFS_LATCH);
    `CHK("latch", 32'h0000_0000, rd_val)
    `CHK("pad", 40'h00_0000_0000, PAD)
  endtask : t_reset

  // Every mode code on pin seven, with latch and peripheral opposed, so a
  // swapped source shows up; pin zero must stay floating throughout.
  task automatic t_modes();
    logic [4:0] got;
    for (int i = 0; i < 7; i++) begin
      for (int l = 0; l < 2; l++) begin
        @(posedge CLK);
        ALT_OUT <= {~l[0], 7'h7F};
        wr(`GPM_OFS_MODE_HI, {16'h0, codes[i], 12'h444});
        wr(`GPM_OFS_LATCH, {24'h0, l[0], 7'h00});
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        got = {PAD[7].analog, PAD[7].pull_up, PAD[7].pull_down, PAD[7].oe, PAD[7].oe & PAD[7].out};
        `CHK("pad7", exp_pad(codes[i], l[0], ~l[0]), got)
        `CHK("pad0", 5'h00, PAD[0])
        rd(`GPM_OFS_MODE_HI);
        `CHK("mode_hi", {16'h0, codes[i], 12'h444}, rd_val)
      end
    end
  endtask : t_modes

  // A set write adds ones and keeps the rest of the latch.
  task automatic t_set();
    wr(`GPM_OFS_LATCH, 32'h05);
    wr(`GPM_OFS_SET, 32'h80);
    rd(`GPM_OFS_LATCH);
    `CHK("latch", 32'h85, rd_val)
    wr(`GPM_OFS_CLR, 32'h04);
    rd(`GPM_OFS_LATCH);
    `CHK("latch", 32'h81, rd_val)
    rd(`GPM_OFS_SET);
    `CHK("set_read", 32'h00, rd_val)
  endtask : t_set

  // Low word: pin zero push-pull from the latch, pin one an undefined code.
  task automatic t_low();
    wr(`GPM_OFS_MODE_LO, 32'h4421);
    rd(`GPM_OFS_MODE_LO);
    `CHK("mode_lo", 32'h4421, rd_val)
    @(posedge CLK);
    @(negedge CLK);
    `CHK("pad0", 5'h03, PAD[0])
    `CHK("pad1", 5'h00, PAD[1])
  endtask : t_low

  // Pin seven grounded under pull-up, then raised; the synchroniser must
  // hide the change from a read issued at once. Analog forces a one.
  task automatic t_input();
    wr(`GPM_OFS_MODE_HI, 32'h8444);
    repeat (4) @(posedge CLK);
    rd(`GPM_OFS_INPUT);
    `CHK("input", 32'h00, rd_val)
    @(posedge CLK);
    PIN_IN <= 8'h80;
    rd(`GPM_OFS_INPUT);
    `CHK("input", 32'h00, rd_val)
    repeat (3) @(posedge CLK);
    rd(`GPM_OFS_INPUT);
    `CHK("input", 32'h80, rd_val)
    @(posedge CLK);
    PIN_IN <= 8'h00;
    wr(`GPM_OFS_MODE_HI, 32'h0444);
    repeat (4) @(posedge CLK);
    rd(`GPM_OFS_INPUT);
    `CHK("input", 32'h80, rd_val)
  endtask : t_input

  // ----------------------------------------------------------------
  // Verdict, clock, main sequence and watchdog
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Free-running clock.
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    RESET = 1'b1;
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    PIN_IN = 8'h00;
    ALT_OUT = 8'h00;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_modes();
    t_set();
    t_low();
    t_input();
    print_verdict();
  end

  // The scenarios need some 190 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    print_verdict();
  end

endmodule : testbench

`default_nettype wire
